/* File: hw/see_pkg.sv */
/*
  shared constants and types of the two-wire serial eeprom slave:
  timing counts, array sizes, device type codes, fsm states and the
  word carried through the write buffer.
  assumes a 100 MHz system clock; nothing else is needed to compile it.
*/
package see_pkg;

  // ==========================================================
  // timing
  // ==========================================================
  localparam int CLK_HZ = 100_000_000;               // system clock rate
  localparam int WRITE_MS = 5;                       // longest self-timed write, in ms
  localparam int WRITE_CYCLES = WRITE_MS * (CLK_HZ / 1000); // rounded down
  localparam int CELL_CYCLES = 4;                    // settle gap between two cell writes

  // ==========================================================
  // array geometry
  // ==========================================================
  localparam int SMALL_WORDS = 512;                  // 4-kbit variant
  localparam int LARGE_WORDS = 1024;                 // 8-kbit variant
  localparam int ADDR_W = 10;                        // widest word address
  localparam int PAGE_BYTES = 16;                    // page write size
  localparam int SERIAL_BYTES = 16;                  // 128-bit serial number
  localparam int FIFO_DEPTH = 8;                     // write buffer depth

  // ==========================================================
  // device address byte
  // ==========================================================
  localparam logic [3:0] TYPE_ARRAY = 4'ha;          // selects the user array
  localparam logic [3:0] TYPE_SERIAL = 4'hb;         // selects the serial number region
  // arbitrary value, stands in for a factory programmed number
  localparam logic [127:0] SERIAL_DEFAULT = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;

  // ==========================================================
  // bit counter and reset values
  // ==========================================================
  localparam logic [3:0] BIT_LAST = 4'h7;            // eighth bit of a byte
  localparam logic [3:0] BIT_ACK = 4'h8;             // ninth, acknowledge clock
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [4:0] SYNC_RST = 5'h18;           // scl and sda idle high
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,   // waiting for a start
    ST_DEV  = 3'b001,   // device address byte
    ST_WADR = 3'b011,   // word address byte
    ST_WDAT = 3'b010,   // write data bytes
    ST_RDAT = 3'b110,   // read data bytes
    ST_SKIP = 3'b111    // not selected, wait for start or stop
  } see_state_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;  // array word address
    logic [7:0] data;         // byte to program
  } see_wr_s;

endpackage : see_pkg

/* File: hw/see_fifo.sv */
/*
  small synchronous fifo with valid and ready on both sides.
  assumes one clock, a synchronous active-low reset and a power-of-two depth.
*/
`timescale 1ns/1ps
module see_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  // ==========================================================
  // storage and pointers
  // ==========================================================
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);  // count when full

  logic [WIDTH-1:0] slot_q [DEPTH];  // flop storage
  logic [PW-1:0] wr_ptr_q;           // next slot to fill
  logic [PW-1:0] rd_ptr_q;           // oldest slot
  logic [PW:0] count_q;              // words held

  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  assign in_ready_o = (count_q != FULL);
  assign out_valid_o = (count_q != '0);
  assign out_data_o = slot_q[rd_ptr_q];

  // pointer and count update
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end

  // data write, no reset needed on storage
  always_ff @(posedge sys_clk_i) begin
    if (push) slot_q[wr_ptr_q] <= in_data_i;
  end

endmodule : see_fifo

/* File: hw/see_mem.sv */
/*
  user array: one write port, one read port with registered read data.
  assumes a single clock; contents are undefined until written.
*/
`timescale 1ns/1ps
module see_mem #(
  parameter int WORDS = 512,
  parameter int AW = 9
) (
  input wire logic sys_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  // ==========================================================
  // array of bytes
  // ==========================================================
  logic [7:0] cell_q [WORDS];  // one byte per word

  // write port and registered read port
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) cell_q[wr_addr_i] <= wr_data_i;
    rd_data_o <= cell_q[rd_addr_i];
  end

endmodule : see_mem

/* File: hw/see_top.sv */
/*
  two-wire serial eeprom slave: protocol engine, write buffer, user array,
  read-only serial number and self-timed write timer.
  assumes scl_i is the master's clock (stops between frames), sda is an
  open-drain wire resolved outside, and sys_clk_i runs at 100 MHz.
*/
`timescale 1ns/1ps
module see_top #(
  parameter bit LARGE = 1'b0,                          // 0: 4-kbit, 1: 8-kbit
  parameter bit PINLESS = 1'b0,                        // select pins absent, read as zero
  parameter int WR_CYCLES = see_pkg::WRITE_CYCLES,     // self-timed write length
  parameter int CELL_WAIT = see_pkg::CELL_CYCLES,      // gap between cell writes
  parameter int BUF_DEPTH = see_pkg::FIFO_DEPTH,       // write buffer depth
  parameter logic [127:0] SERIAL_VALUE = see_pkg::SERIAL_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic select_pin_upper_i,
  input wire logic select_pin_lower_i,
  input wire logic write_protect_i,
  output logic busy_o
);
  // ==========================================================
  // sizes
  // ==========================================================
  localparam int WORDS = LARGE ? see_pkg::LARGE_WORDS : see_pkg::SMALL_WORDS;
  localparam int AW = $clog2(WORDS);
  localparam int BW = $clog2(WR_CYCLES + 1);
  localparam int CW = $clog2(CELL_WAIT + 1);
  localparam int FW = $bits(see_pkg::see_wr_s);

  // ==========================================================
  // link clock domain
  // ==========================================================
  logic rx_bit_q;   // sda as sampled by the last scl rise
  logic tx_q;       // pull-low request held for one scl period
  logic drive_q;    // system side request, read at scl fall
  logic en_q;       // tx_q known valid since reset

  // data in is taken on the rising scl edge
  always_ff @(posedge scl_i) begin
    rx_bit_q <= sda_i;
  end

  // data out changes only after the falling edge; drive_q settles
  // within a few system cycles of the rise, long before the fall
  always_ff @(negedge scl_i) begin
    tx_q <= drive_q;
  end

  // open drain: the level driven is always low, only the enable moves
  assign sda_o = 1'b0;
  assign sda_oe_o = tx_q & en_q;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [4:0] meta_q;  // first stage, read only by sync_q
  logic [4:0] sync_q;  // {scl, sda, wp, upper, lower}
  logic [1:0] prev_q;  // previous synced scl and sda

  // two flops on every asynchronous pin
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= see_pkg::SYNC_RST;
      sync_q <= see_pkg::SYNC_RST;
      prev_q <= see_pkg::SYNC_RST[4:3];
    end else begin
      meta_q <= {scl_i, sda_i, write_protect_i, select_pin_upper_i, select_pin_lower_i};
      sync_q <= meta_q;
      prev_q <= sync_q[4:3];
    end
  end

  // ==========================================================
  // bus event decode
  // ==========================================================
  wire scl_s = sync_q[4];
  wire sda_s = sync_q[3];
  wire wp_s = sync_q[2];
  wire up_v = PINLESS ? 1'b0 : sync_q[1];
  wire lo_v = PINLESS ? 1'b0 : sync_q[0];

  wire scl_rise = scl_s & ~prev_q[1];
  wire scl_fall = ~scl_s & prev_q[1];
  wire start_ev = scl_s & prev_q[1] & prev_q[0] & ~sda_s;
  wire stop_ev = scl_s & prev_q[1] & ~prev_q[0] & sda_s;

  // ==========================================================
  // protocol state
  // ==========================================================
  see_pkg::see_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;                      // rises within the byte
  logic [7:0] sh_q, sh_d;                        // shift register
  logic [see_pkg::ADDR_W-1:0] addr_q, addr_d;    // word address pointer
  logic rw_q, rw_d;                              // read when set
  logic sn_q, sn_d;                              // serial region selected
  logic drive_d;
  logic acked_q, acked_d;                        // current byte acknowledged
  logic wr_any_q, wr_any_d;                      // bytes stored this frame
  logic [BW-1:0] busy_cnt_q;                     // self-timed write timer
  logic [CW-1:0] cell_q;                         // drain settle counter
  logic [7:0] sn_byte_q;                         // serial byte at addr_q
  logic [7:0] mem_rd;                            // array byte at addr_q

  wire [7:0] byte_in = {sh_q[6:0], rx_bit_q};
  wire byte_done = scl_rise & (cnt_q == see_pkg::BIT_LAST);
  wire ack_clk = scl_rise & (cnt_q == see_pkg::BIT_ACK);
  wire [7:0] rd_byte = sn_q ? sn_byte_q : mem_rd;

  // device address match
  wire type_ok = (byte_in[7:4] == see_pkg::TYPE_ARRAY) | (byte_in[7:4] == see_pkg::TYPE_SERIAL);
  wire pin_ok = LARGE ? (byte_in[3] == up_v) : (byte_in[3:2] == {up_v, lo_v});
  wire [1:0] hi_bits = LARGE ? byte_in[2:1] : {1'b0, byte_in[1]};

  // write buffer
  logic buf_in_ready;
  logic buf_out_valid;
  see_pkg::see_wr_s buf_out;
  wire busy = (busy_cnt_q != '0) | buf_out_valid;
  wire dev_ack = type_ok & pin_ok & ~busy;
  wire push_ok = ~wp_s & ~sn_q;
  wire buf_in_valid = byte_done & (state_q == see_pkg::ST_WDAT) & push_ok;
  // read pointer wraps at the array end; upper bits zeroed so no empty slice in the large variant
  wire [see_pkg::ADDR_W-1:0] addr_inc = see_pkg::ADDR_W'(AW'(addr_q[AW-1:0] + 1'b1));
  wire [see_pkg::ADDR_W-1:0] page_inc = {addr_q[see_pkg::ADDR_W-1:4], 4'(addr_q[3:0] + 4'h1)};
  wire buf_pop = buf_out_valid & (cell_q == '0);

  // next-state logic of the byte engine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    rw_d = rw_q;
    sn_d = sn_q;
    drive_d = drive_q;
    acked_d = acked_q;
    wr_any_d = wr_any_q;
    if (start_ev) begin
      // every command begins here, repeated start included
      state_d = see_pkg::ST_DEV;
      cnt_d = see_pkg::CNT_RST;
      drive_d = 1'b0;
    end else if (stop_ev) begin
      state_d = see_pkg::ST_IDLE;
      drive_d = 1'b0;
      wr_any_d = 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        see_pkg::ST_DEV, see_pkg::ST_WADR, see_pkg::ST_WDAT: begin
          if (cnt_q != see_pkg::BIT_ACK) begin
            sh_d = byte_in;
            cnt_d = cnt_q + 4'h1;
          end
          if (byte_done) begin
            // decide the acknowledge for the ninth clock
            if (state_q == see_pkg::ST_DEV) begin
              acked_d = dev_ack;
              drive_d = dev_ack;
              if (dev_ack) begin
                rw_d = byte_in[0];
                sn_d = (byte_in[7:4] == see_pkg::TYPE_SERIAL);
                addr_d[see_pkg::ADDR_W-1:8] = hi_bits;
              end
            end else if (state_q == see_pkg::ST_WADR) begin
              acked_d = 1'b1;
              drive_d = 1'b1;
              addr_d[7:0] = byte_in;
            end else begin
              // a full buffer refuses the byte
              acked_d = buf_in_ready;
              drive_d = buf_in_ready;
              if (buf_in_ready) begin
                addr_d = page_inc;
                wr_any_d = wr_any_q | push_ok;
              end
            end
          end else if (ack_clk) begin
            cnt_d = see_pkg::CNT_RST;
            drive_d = 1'b0;
            if (!acked_q) begin
              state_d = see_pkg::ST_SKIP;
            end else if (state_q == see_pkg::ST_DEV && rw_q) begin
              state_d = see_pkg::ST_RDAT;
              sh_d = rd_byte;
              drive_d = ~rd_byte[7];
            end else if (state_q == see_pkg::ST_DEV) begin
              state_d = see_pkg::ST_WADR;
            end else begin
              state_d = see_pkg::ST_WDAT;
            end
          end
        end
        see_pkg::ST_RDAT: begin
          if (cnt_q < see_pkg::BIT_LAST) begin
            // present the next bit after the coming fall
            sh_d = {sh_q[6:0], 1'b0};
            drive_d = ~sh_q[6];
            cnt_d = cnt_q + 4'h1;
          end else if (cnt_q == see_pkg::BIT_LAST) begin
            // release for the master's acknowledge, fetch next byte
            drive_d = 1'b0;
            addr_d = sn_q ? {addr_q[see_pkg::ADDR_W-1:4], 4'(addr_q[3:0] + 4'h1)} : addr_inc;
            cnt_d = cnt_q + 4'h1;
          end else begin
            cnt_d = see_pkg::CNT_RST;
            if (!rx_bit_q) begin
              sh_d = rd_byte;
              drive_d = ~rd_byte[7];
            end else begin
              state_d = see_pkg::ST_SKIP;
              drive_d = 1'b0;
            end
          end
        end
        default: begin
          // idle or deselected: ignore clocks
          drive_d = 1'b0;
        end
      endcase
    end
  end

  // byte engine registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= see_pkg::ST_IDLE;
      cnt_q <= see_pkg::CNT_RST;
      sh_q <= see_pkg::BYTE_RST;
      addr_q <= see_pkg::ADDR_RST;
      rw_q <= 1'b0;
      sn_q <= 1'b0;
      drive_q <= 1'b0;
      acked_q <= 1'b0;
      wr_any_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      rw_q <= rw_d;
      sn_q <= sn_d;
      drive_q <= drive_d;
      acked_q <= acked_d;
      wr_any_q <= wr_any_d;
    end
  end

  // output enable stays off until tx_q has been loaded after reset
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) en_q <= 1'b0;
    else if (scl_fall) en_q <= 1'b1;
  end

  // ==========================================================
  // self-timed write cycle
  // ==========================================================
  // starts at the stop that ends a write; device refuses its address meanwhile
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      busy_cnt_q <= '0;
      busy_o <= 1'b0;
    end else begin
      if (stop_ev && wr_any_q) busy_cnt_q <= BW'(WR_CYCLES);
      else if (busy_cnt_q != '0) busy_cnt_q <= busy_cnt_q - 1'b1;
      busy_o <= busy;
    end
  end

  // ==========================================================
  // write buffer and array
  // ==========================================================
  see_fifo #(
    .WIDTH(FW),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i({addr_q, byte_in}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(cell_q == '0),
    .out_data_o(buf_out)
  );

  // drain pacing: each cell write needs a short settle time
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) cell_q <= '0;
    else if (buf_pop) cell_q <= CW'(CELL_WAIT);
    else if (cell_q != '0) cell_q <= cell_q - 1'b1;
  end

  see_mem #(
    .WORDS(WORDS),
    .AW(AW)
  ) u_mem (
    .sys_clk_i(sys_clk_i),
    .wr_en_i(buf_pop),
    .wr_addr_i(buf_out.addr[AW-1:0]),
    .wr_data_i(buf_out.data),
    .rd_addr_i(addr_q[AW-1:0]),
    .rd_data_o(mem_rd)
  );

  // serial number lookup, no write path exists
  always_ff @(posedge sys_clk_i) begin
    sn_byte_q <= SERIAL_VALUE[{addr_q[3:0], 3'b000} +: 8];
  end

endmodule : see_top

/* File: tb/see_master.sv */
/*
  bus master model for the eeprom slave: start, stop, byte out, byte in.
  assumes sda_i is the resolved wire with a pull-up; scl stands high between frames.
*/
`timescale 1ns/1ps
module see_master (
  input wire logic link_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // ==========
  // bus idle: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // one bit: data set while scl low, sampled in the high phase
  task automatic bit_io(input logic b, output logic s);
    @(posedge link_clk_i) sda_oe_o = ~b;
    @(posedge link_clk_i) scl_o = 1'b1;
    @(posedge link_clk_i) s = sda_i;
    @(posedge link_clk_i) scl_o = 1'b0;
  endtask : bit_io

  // data falls while scl high, also as repeated start
  task automatic start();
    @(posedge link_clk_i) sda_oe_o = 1'b0;
    @(posedge link_clk_i) scl_o = 1'b1;
    @(posedge link_clk_i) sda_oe_o = 1'b1;
    @(posedge link_clk_i) scl_o = 1'b0;
  endtask : start

  // data rises while scl high, then bus free time
  task automatic stop();
    @(posedge link_clk_i) sda_oe_o = 1'b1;
    @(posedge link_clk_i) scl_o = 1'b1;
    @(posedge link_clk_i) sda_oe_o = 1'b0;
    @(posedge link_clk_i);
  endtask : stop

  // eight bits msb first, then sample the slave's acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send_byte

  // eight bits in, then acknowledge low or a final high
  task automatic rd_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(last, s);
  endtask : rd_byte
endmodule : see_master

/* File: tb/see_top_properties.sv */
/*
  port checker of the eeprom slave.
  assumes bind to see_top; scl and sda are sampled as data in the sys domain.
*/
`timescale 1ns/1ps
module see_top_properties #(
  parameter int WR_CYCLES = 200
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic write_protect_i,
  input wire logic busy_o
);
  localparam int BUSY_MAX = WR_CYCLES + 256; // timer plus buffer drain
  // ==========
  // helpers: start detect, scl rises since start, busy length
  logic scl_q, sda_q, start_w;
  logic [3:0] rise_q, rise_d;
  int busy_q, busy_d;
  assign start_w = scl_i && scl_q && sda_q && !sda_i;
  assign rise_d = start_w ? 4'h0 : (scl_i && !scl_q && rise_q != 4'hf) ? rise_q + 4'h1 : rise_q;
  assign busy_d = busy_o ? busy_q + 32'h1 : 32'h0;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rise_q <= 4'h0;
      busy_q <= 32'h0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      rise_q <= rise_d;
      busy_q <= busy_d;
    end
  end
  // ==========
  // properties
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_SDA_VALUE_LOW: assert property (sda_o == 1'b0)
    else $error("sda data value not low");
  AST_OE_MOVES_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda drive changed while scl high");
  AST_QUIET_AFTER_RESET: assert property ($rose(rst_n_i) |-> !sda_oe_o && !busy_o)
    else $error("outputs active after reset");
  AST_BUSY_BOUND: assert property (busy_q <= BUSY_MAX)
    else $error("write cycle too long");
  AST_PROTECT_NO_CYCLE: assert property ($rose(busy_o) |-> !write_protect_i)
    else $error("write cycle under write protect");
  AST_START_RELEASED: assert property (scl_i && $fell(sda_i) |-> !sda_oe_o [*8])
    else $error("slave drives at start");
  AST_STOP_RELEASED: assert property (scl_i && $rose(sda_i) |=> !sda_oe_o [*8])
    else $error("slave drives after stop");
  AST_ACK_NINTH: assert property ($rose(sda_oe_o) |-> rise_q >= 4'h8)
    else $error("slave drove before ninth clock");
endmodule : see_top_properties

bind see_top see_top_properties #(.WR_CYCLES(WR_CYCLES)) see_top_properties_i (
  .sys_clk_i(sys_clk_i),
  .rst_n_i(rst_n_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .write_protect_i(write_protect_i),
  .busy_o(busy_o)
);

/* File: tb/tb_top.sv */
/*
  testbench of the eeprom slave: page, busy, protect, serial, select.
  assumes see_master drives the bus and sda has a pull-up.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int WRC = 2000; // shortened self-timed write
  localparam int LIMIT = 90000; // run ceiling in sys clocks
  logic sys_clk, rst_n, link_clk, wp, pin_up, pin_lo, scl, m_oe, dev_oe, dev_o, busy, sda;
  int err_count, checked, cycles;
  assign sda = ~m_oe & ((dev_oe === 1'b1) ? dev_o : 1'b1); // pull-up wire
  see_top #(.WR_CYCLES(WRC), .CELL_WAIT(2)) see_top_i (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(dev_o),
    .sda_oe_o(dev_oe), .select_pin_upper_i(pin_up), .select_pin_lower_i(pin_lo),
    .write_protect_i(wp), .busy_o(busy));
  see_master see_master_i (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
  // ==========
  // clocks and run ceiling
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      report_and_stop();
    end
  end
  // ==========
  // compares and verdict
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // ==========
  // bus frames: write, random read, wait for the write cycle
  task automatic put(input logic [3:0] t, input logic [9:0] a, input logic [7:0] d[$],
                     output logic ok);
    logic k;
    see_master_i.start();
    see_master_i.send_byte({t, pin_up, pin_lo, a[8], 1'b0}, ok);
    see_master_i.send_byte(a[7:0], k);
    ok = ok & k;
    foreach (d[i]) begin
      see_master_i.send_byte(d[i], k);
      ok = ok & k;
    end
    see_master_i.stop();
  endtask : put
  task automatic get(input logic [3:0] t, input logic [9:0] a, input int n,
                     output logic [7:0] q[$]);
    logic k;
    logic [7:0] b;
    q = {};
    see_master_i.start();
    see_master_i.send_byte({t, pin_up, pin_lo, a[8], 1'b0}, k);
    see_master_i.send_byte(a[7:0], k);
    see_master_i.start();
    see_master_i.send_byte({t, pin_up, pin_lo, a[8], 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      see_master_i.rd_byte(i == n - 1, b);
      q.push_back(b);
    end
    see_master_i.stop();
  endtask : get
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (20) @(negedge sys_clk);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk_bit("busy after write", 1'b0, busy);
  endtask : wait_idle
  // ==========
  // scenarios
  task automatic t_page();
    logic ok;
    logic [7:0] q[$];
    put(see_pkg::TYPE_ARRAY, 10'h01e, {8'he1}, ok);
    wait_idle();
    put(see_pkg::TYPE_ARRAY, 10'h11e, {8'h5a, 8'ha5, 8'h3c}, ok);
    chk_bit("page acks", 1'b1, ok);
    wait_idle();
    get(see_pkg::TYPE_ARRAY, 10'h11e, 2, q);
    chk_byte("byte 11e", 8'h5a, q[0]);
    chk_byte("byte 11f", 8'ha5, q[1]);
    get(see_pkg::TYPE_ARRAY, 10'h110, 1, q);
    chk_byte("wrapped byte 110", 8'h3c, q[0]);
    get(see_pkg::TYPE_ARRAY, 10'h01e, 1, q);
    chk_byte("byte 01e", 8'he1, q[0]);
    put(see_pkg::TYPE_ARRAY, 10'h1ff, {8'hc3}, ok);
    wait_idle();
    get(see_pkg::TYPE_ARRAY, 10'h1ff, 1, q);
    chk_byte("last byte", 8'hc3, q[0]);
    $display("test page done");
  endtask : t_page
  task automatic t_busy();
    logic ok;
    logic [7:0] q[$];
    put(see_pkg::TYPE_ARRAY, 10'h040, {8'h77}, ok);
    repeat (10) @(negedge sys_clk);
    chk_bit("busy after stop", 1'b1, busy);
    see_master_i.start();
    see_master_i.send_byte({see_pkg::TYPE_ARRAY, pin_up, pin_lo, 2'b00}, ok);
    see_master_i.stop();
    chk_bit("ack while busy", 1'b0, ok);
    wait_idle();
    get(see_pkg::TYPE_ARRAY, 10'h040, 1, q);
    chk_byte("byte 040", 8'h77, q[0]);
    $display("test busy done");
  endtask : t_busy
  task automatic t_wp();
    logic ok;
    logic [7:0] q[$];
    @(negedge sys_clk);
    wp = 1'b1;
    repeat (5) @(negedge sys_clk);
    put(see_pkg::TYPE_ARRAY, 10'h040, {8'h11}, ok);
    chk_bit("protected acks", 1'b1, ok);
    wait_idle();
    get(see_pkg::TYPE_ARRAY, 10'h040, 1, q);
    chk_byte("protected byte", 8'h77, q[0]);
    @(negedge sys_clk);
    wp = 1'b0;
    $display("test protect done");
  endtask : t_wp
  task automatic t_serial();
    logic ok;
    logic [7:0] q[$];
    put(see_pkg::TYPE_ARRAY, 10'h000, {8'h99}, ok);
    wait_idle();
    put(see_pkg::TYPE_SERIAL, 10'h000, {8'hff, 8'hff}, ok);
    wait_idle();
    get(see_pkg::TYPE_SERIAL, 10'h000, 16, q);
    for (int k = 0; k < 16; k++) begin
      chk_byte("serial byte", see_pkg::SERIAL_DEFAULT[8*k +: 8], q[k]);
    end
    get(see_pkg::TYPE_ARRAY, 10'h000, 1, q);
    chk_byte("array byte 000", 8'h99, q[0]);
    $display("test serial done");
  endtask : t_serial
  task automatic t_select();
    logic k;
    for (int p = 0; p < 4; p++) begin
      @(negedge sys_clk);
      {pin_up, pin_lo} = p[1:0];
      repeat (5) @(negedge sys_clk);
      // i = 0 sends every select bit as zero, the form a pinless part needs
      for (int i = 0; i < 5; i++) begin
        see_master_i.start();
        see_master_i.send_byte({(i == 4) ? 4'h5 : see_pkg::TYPE_ARRAY, i[1:0], 2'b00}, k);
        see_master_i.stop();
        chk_bit("select ack", i == p, k);
      end
    end
    $display("test select done");
  endtask : t_select
  // ==========
  // main sequence
  initial begin
    rst_n = 1'b0;
    wp = 1'b0;
    pin_up = 1'b1;
    pin_lo = 1'b0;
    err_count = 0;
    checked = 0;
    cycles = 0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    t_page();
    t_busy();
    t_wp();
    t_serial();
    t_select();
    report_and_stop();
  end
endmodule : tb_top
